/* File: core/lmd_pkg.sv */
// Shared constants and types for the lens direct-motion controller.
// Assumes an upstream parser has turned host text into one lmd_cmd_t per command.
package lmd_pkg;

   localparam int          POS_W      = 16;        // Position and argument width
   localparam int          NUM_MOTORS = 2;         // Zoom and focus only
   localparam logic [15:0] MOTOR_ZOOM = 16'h0000;  // Selector for zoom
   localparam logic [15:0] MOTOR_FOCUS = 16'h0001; // Selector for focus
   localparam logic [15:0] ARG_OFF    = 16'h0000;  // Off / positional
   localparam logic [15:0] ARG_ON     = 16'h0001;  // On / tracking

   // Reset values of the user settings
   localparam logic [15:0] RANGE_LO_RST = 16'h0000;
   localparam logic [15:0] RANGE_HI_RST = 16'hffff;
   localparam logic [3:0]  DEPTH_RST    = 4'h4;
   localparam logic [3:0]  GAIN_RST     = 4'h2;
   localparam logic        ENABLE_RST   = 1'b1;
   localparam logic [15:0] PHYS_MAX_DEF = 16'hffff; // Full physical travel

   // Timing: motor top speed and tracking update tick
   localparam int CLK_NS   = 20;
   localparam int STEP_NS  = 50000;                       // Least step period
   localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
   localparam int TICK_NS  = 1000000;                     // Tracking update period
   localparam int TICK_CYC = TICK_NS / CLK_NS;

   // Tracking speed scale
   localparam logic signed [23:0] VEL_MAX = 24'sh000100;  // Speed at top rate
   localparam logic [23:0] STEP_THR = 24'(STEP_CYC) * 24'h000100;

   // Parsed host commands
   typedef enum logic [3:0] {
      OP_NONE   = 4'h0,
      OP_CENTRE = 4'h1,
      OP_LAMP   = 4'h2,
      OP_ENABLE = 4'h3,
      OP_MOVE   = 4'h4,
      OP_RANGE  = 4'h5,
      OP_DEPTH  = 4'h6,
      OP_GAIN   = 4'h7,
      OP_QPARAM = 4'h8,
      OP_QPOS   = 4'h9
   } lmd_op_t;

   typedef enum logic [1:0] {
      M_IDLE  = 2'b00,
      M_POS   = 2'b01,
      M_TRACK = 2'b10
   } lmd_mode_t;

   typedef struct packed {
      lmd_op_t     op;
      logic [1:0]  nargs;  // Numeric arguments present
      logic [15:0] a0;
      logic [15:0] a1;
      logic [15:0] a2;
   } lmd_cmd_t;

   typedef struct packed {
      logic        last;
      logic [15:0] data;
   } lmd_rsp_t;

endpackage : lmd_pkg

/* File: core/lmd_top.sv */
// Lens direct-motion controller: settings, motor stepping, queries.
// Assumes commands are already parsed and inputs are synchronous to CLOCK.
//
// How it works
// - Centre command centres motors, reloads hardware positions
// - Older mount: centre command requests calibration
// - Lamp conditioning argument 0 off, 1 on
// - Enable command: 0 disables, 1 enables
// - Enabled at reset; disabled ignores moves
// - Selector 0 zoom, 1 focus only
// - Mode 0 positional, 1 tracking
// - Positional moves to target, then stops
// - New move cancels old, from current position
// - Positional follows latest target at top speed
// - Tracking speed from input change; stops soon after
// - Depth sets tracking averaging length
// - Depth, gain affect tracking only; small gain faster
// - Range defaults 0 to 65535, start below end
// - User targets scale onto full physical travel
// - Range, depth, gain keywords set parameters
// - Parameter query returns five values in order
// - Position query returns user-scaled position
// - Automatic motion outranks direct motion
// - Omitted mode means positional
`timescale 1ns/1ps
module lmd_top
   import lmd_pkg::*;
#(
   parameter logic [15:0] PHYS_MAX = PHYS_MAX_DEF, // Physical travel end
   parameter int          TICK_LEN = TICK_CYC      // Tracking tick, cycles
)(
   input  wire logic                         CLOCK,
   input  wire logic                         RST_N,
   input  wire logic                         CE,
   input  wire logic                         CMD_VALID,
   input  wire lmd_cmd_t                     CMD,
   output logic                              CMD_READY,
   input  wire logic                         AUTO_BUSY,
   input  wire logic                         LEGACY_MOUNT,
   input  wire logic [NUM_MOTORS-1:0][15:0]  POS_FB,
   output logic [NUM_MOTORS-1:0]             STEP,
   output logic [NUM_MOTORS-1:0]             DIR,
   output logic [NUM_MOTORS-1:0]             MOTOR_BUSY,
   output logic [NUM_MOTORS-1:0][15:0]       POS,
   output logic                              CAL_REQ,
   output logic                              LAMP_COND_ON,
   output logic                              DM_ENABLED,
   output logic                              RSP_VALID,
   output lmd_rsp_t                          RSP
);

   // User scale to physical, clamping into range
   function automatic logic [15:0] to_phys(input logic [15:0] u, input logic [15:0] lo,
                                           input logic [15:0] hi);
      logic [15:0] c;
      logic [31:0] q;
      c = (u < lo) ? lo : ((u > hi) ? hi : u);
      q = (32'(16'(c - lo)) * 32'(PHYS_MAX)) / 32'(16'(hi - lo));
      return q[15:0];
   endfunction : to_phys

   // Physical to user scale
   function automatic logic [15:0] to_user(input logic [15:0] p, input logic [15:0] lo,
                                           input logic [15:0] hi);
      logic [31:0] q;
      q = (32'(p) * 32'(16'(hi - lo))) / 32'(PHYS_MAX);
      return 16'(lo + q[15:0]);
   endfunction : to_user

   // Settings and answer state
   logic        en_q, en_d;           // Direct motion enable
   logic [15:0] lo_q, lo_d;           // Range start
   logic [15:0] hi_q, hi_d;           // Range end
   logic [3:0]  depth_q, depth_d;     // Accumulator depth (shift)
   logic [3:0]  gain_q, gain_d;       // Acceleration gain (shift)
   logic        lamp_q, lamp_d;       // Lamp conditioning
   logic        cal_q, cal_d;         // Calibration request pulse
   logic        qon_q, qon_d;         // Parameter answer running
   logic [2:0]  qidx_q, qidx_d;       // Parameter answer index
   logic        rv_q, rv_d;           // Answer valid
   lmd_rsp_t    rsp_q, rsp_d;         // Answer word
   logic [31:0] tick_q, tick_d;       // Tracking tick divider
   logic        take;                 // Command accepted this cycle
   logic        tick;                 // Tracking update strobe
   logic        centre;               // Centre all motors this cycle
   logic [15:0] tgt_phys;             // Scaled move target
   logic [NUM_MOTORS-1:0][15:0] pos_w; // Motor positions

   // Answers are serialised, so commands wait while a parameter answer is going out
   assign CMD_READY = ~qon_q;
   assign take      = CMD_VALID & CMD_READY & CE;
   assign tick      = (tick_q == 32'(TICK_LEN - 1));
   assign centre    = take & (CMD.op == OP_CENTRE) & ~LEGACY_MOUNT;
   assign tgt_phys  = to_phys(CMD.a1, lo_q, hi_q);

   // Settings, queries and tick next state
   always_comb
   begin
      en_d    = en_q;
      lo_d    = lo_q;
      hi_d    = hi_q;
      depth_d = depth_q;
      gain_d  = gain_q;
      lamp_d  = lamp_q;
      cal_d   = 1'b0;
      qon_d   = qon_q;
      qidx_d  = qidx_q;
      rv_d    = 1'b0;
      rsp_d   = rsp_q;
      tick_d  = tick ? 32'h0 : 32'(tick_q + 32'h1);
      if (take)
      begin
         unique case (CMD.op)
            OP_CENTRE: cal_d = LEGACY_MOUNT;
            OP_LAMP:
            begin
               if (CMD.a0 == ARG_OFF) lamp_d = 1'b0;
               else if (CMD.a0 == ARG_ON) lamp_d = 1'b1;
            end
            OP_ENABLE:
            begin
               if (CMD.a0 == ARG_OFF) en_d = 1'b0;
               else if (CMD.a0 == ARG_ON) en_d = 1'b1;
            end
            OP_RANGE:
            begin
               // Bad range keeps the old scale
               if (CMD.a0 < CMD.a1)
               begin
                  lo_d = CMD.a0;
                  hi_d = CMD.a1;
               end
            end
            OP_DEPTH:  depth_d = CMD.a0[3:0];
            OP_GAIN:   gain_d  = CMD.a0[3:0];
            OP_QPARAM:
            begin
               qon_d  = 1'b1;
               qidx_d = 3'h0;
            end
            OP_QPOS:
            begin
               // Unknown motor gets no answer
               if (CMD.a0 <= MOTOR_FOCUS)
               begin
                  rv_d       = 1'b1;
                  rsp_d.last = 1'b1;
                  rsp_d.data = to_user(pos_w[CMD.a0[0]], lo_q, hi_q);
               end
            end
            default: ;
         endcase
      end
      if (qon_q)
      begin
         // Enable, low, high, depth, gain
         rv_d       = 1'b1;
         rsp_d.last = (qidx_q == 3'h4);
         unique case (qidx_q)
            3'h0:    rsp_d.data = {15'h0, en_q};
            3'h1:    rsp_d.data = lo_q;
            3'h2:    rsp_d.data = hi_q;
            3'h3:    rsp_d.data = {12'h0, depth_q};
            default: rsp_d.data = {12'h0, gain_q};
         endcase
         qidx_d = 3'(qidx_q + 3'h1);
         if (qidx_q == 3'h4) qon_d = 1'b0;
      end
   end

   // Settings registers
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         en_q    <= ENABLE_RST;
         lo_q    <= RANGE_LO_RST;
         hi_q    <= RANGE_HI_RST;
         depth_q <= DEPTH_RST;
         gain_q  <= GAIN_RST;
         lamp_q  <= 1'b0;
         cal_q   <= 1'b0;
         qon_q   <= 1'b0;
         qidx_q  <= 3'h0;
         rv_q    <= 1'b0;
         rsp_q   <= '0;
         tick_q  <= 32'h0;
      end
      else if (CE)
      begin
         en_q    <= en_d;
         lo_q    <= lo_d;
         hi_q    <= hi_d;
         depth_q <= depth_d;
         gain_q  <= gain_d;
         lamp_q  <= lamp_d;
         cal_q   <= cal_d;
         qon_q   <= qon_d;
         qidx_q  <= qidx_d;
         rv_q    <= rv_d;
         rsp_q   <= rsp_d;
         tick_q  <= tick_d;
      end
   end

   assign DM_ENABLED   = en_q;
   assign LAMP_COND_ON = lamp_q;
   assign CAL_REQ      = cal_q;
   assign RSP_VALID    = rv_q;
   assign RSP          = rsp_q;
   assign POS          = pos_w;

   // One motion engine per motor
   for (genvar m = 0; m < NUM_MOTORS; m++)
   begin : g_motor
      lmd_mode_t          mode_q, mode_d;   // Motion state
      logic [15:0]        pos_q, pos_d;     // Tracked position
      logic [15:0]        tgt_q, tgt_d;     // Positional target
      logic [15:0]        last_q, last_d;   // Previous tracking input
      logic signed [23:0] acc_q, acc_d;     // Change accumulator
      logic signed [23:0] vel_q, vel_d;     // Smoothed speed
      logic [23:0]        frac_q, frac_d;   // Step phase
      logic [31:0]        div_q, div_d;     // Top-speed divider
      logic               step_q, step_d;   // Step pulse
      logic               dir_q, dir_d;     // Direction, 1 = up
      logic               hit;              // Move for this motor
      logic signed [23:0] avg, dv, vt;      // Tracking working values
      logic [23:0]        mag;              // Speed magnitude

      assign hit = take & (CMD.op == OP_MOVE) & en_q & ~AUTO_BUSY
                   & (CMD.a0 == 16'(m))
                   & ((CMD.nargs < 2'd3) | (CMD.a2 <= ARG_ON));

      // Motion next state
      always_comb
      begin
         mode_d = mode_q;
         pos_d  = pos_q;
         tgt_d  = tgt_q;
         last_d = last_q;
         acc_d  = acc_q;
         vel_d  = vel_q;
         frac_d = frac_q;
         div_d  = div_q;
         step_d = 1'b0;
         dir_d  = dir_q;
         avg    = acc_q >>> depth_q;
         vt     = (avg > VEL_MAX) ? VEL_MAX : ((avg < -VEL_MAX) ? -VEL_MAX : avg);
         dv     = (vt - vel_q) >>> gain_q;
         mag    = vel_q[23] ? 24'(-vel_q) : 24'(vel_q);
         if (centre)
         begin
            pos_d  = POS_FB[m];
            tgt_d  = PHYS_MAX >> 1;
            mode_d = M_POS;
         end
         else if (hit)
         begin
            // Position stays put: the new move starts where we are
            if ((CMD.nargs == 2'd3) && (CMD.a2 == ARG_ON))
            begin
               if (mode_q == M_TRACK)
                  acc_d = acc_q + 24'(signed'({1'b0, tgt_phys}) - signed'({1'b0, last_q}));
               else
               begin
                  acc_d = 24'sh0;
                  vel_d = 24'sh0;
               end
               last_d = tgt_phys;
               mode_d = M_TRACK;
            end
            else
            begin
               tgt_d  = tgt_phys;
               mode_d = M_POS;
            end
         end
         else if (!AUTO_BUSY)
         begin
            unique case (mode_q)
               M_POS:
               begin
                  // Top speed: one step per divider period
                  div_d = (div_q == 32'(STEP_CYC - 1)) ? 32'h0 : 32'(div_q + 32'h1);
                  if (pos_q == tgt_q) mode_d = M_IDLE;
                  else if (div_q == 32'(STEP_CYC - 1))
                  begin
                     step_d = 1'b1;
                     dir_d  = tgt_q > pos_q;
                     pos_d  = (tgt_q > pos_q) ? 16'(pos_q + 16'h1) : 16'(pos_q - 16'h1);
                  end
               end
               M_TRACK:
               begin
                  if (tick)
                  begin
                     // Leaky average; tiny residue is dropped so it ends
                     acc_d = (avg == 24'sh0) ? 24'sh0 : acc_q - avg;
                     vel_d = (dv == 24'sh0) ? vt : vel_q + dv;
                     if (acc_q == 24'sh0 && vel_q == 24'sh0) mode_d = M_IDLE;
                  end
                  frac_d = 24'(frac_q + mag);
                  if (frac_d >= STEP_THR)
                  begin
                     frac_d = 24'(frac_d - STEP_THR);
                     // End stops halt tracking motion
                     if (!vel_q[23] && pos_q != PHYS_MAX)
                     begin
                        step_d = 1'b1;
                        dir_d  = 1'b1;
                        pos_d  = 16'(pos_q + 16'h1);
                     end
                     else if (vel_q[23] && pos_q != 16'h0)
                     begin
                        step_d = 1'b1;
                        dir_d  = 1'b0;
                        pos_d  = 16'(pos_q - 16'h1);
                     end
                  end
               end
               default: ;
            endcase
         end
      end

      // Motion registers
      always_ff @(posedge CLOCK or negedge RST_N)
      begin
         if (!RST_N)
         begin
            mode_q <= M_IDLE;
            pos_q  <= 16'h0;
            tgt_q  <= 16'h0;
            last_q <= 16'h0;
            acc_q  <= 24'sh0;
            vel_q  <= 24'sh0;
            frac_q <= 24'h0;
            div_q  <= 32'h0;
            step_q <= 1'b0;
            dir_q  <= 1'b0;
         end
         else if (CE)
         begin
            mode_q <= mode_d;
            pos_q  <= pos_d;
            tgt_q  <= tgt_d;
            last_q <= last_d;
            acc_q  <= acc_d;
            vel_q  <= vel_d;
            frac_q <= frac_d;
            div_q  <= div_d;
            step_q <= step_d;
            dir_q  <= dir_d;
         end
      end

      assign pos_w[m]      = pos_q;
      assign STEP[m]       = step_q;
      assign DIR[m]        = dir_q;
      assign MOTOR_BUSY[m] = (mode_q != M_IDLE);
   end

endmodule : lmd_top

/* File: dv/lmd_host_model.sv */
// Host-side command source for the lens direct-motion controller.
// Assumes the bench calls send() and reads answers itself.
`timescale 1ns/1ps
module lmd_host_model
   import lmd_pkg::*;
(
   input  wire logic clock,
   input  wire logic cmd_ready,
   output lmd_cmd_t  cmd,
   output logic      cmd_valid
);
   // Idle until the bench asks
   initial
   begin
      cmd_valid = 1'b0;
      cmd       = '0;
   end

   // Legal selectors and ranges unless the bench breaks them on purpose
   // Calibration and automatic positioning are settled by the bench first
   task automatic send(input lmd_op_t op, input logic [1:0] n, input logic [15:0] a0, a1, a2);
      int i;
      @(posedge clock);
      #1;
      cmd_valid = 1'b1;
      cmd       = '{op, n, a0, a1, a2};
      // Ready only moves on edges, so mid-cycle look is safe
      for (i = 0; i < 50 && cmd_ready !== 1'b1; i++)
      begin
         @(posedge clock);
         #1;
      end
      @(posedge clock);
      #1;
      cmd_valid = 1'b0;
      // Scramble so stale fields never pass for a command
      cmd       = lmd_cmd_t'(~cmd);
   endtask : send
endmodule : lmd_host_model

/* File: dv/lmd_top_assertions.sv */
// Port checker for the lens direct-motion controller.
// Assumes one clock domain; bound to every lmd_top.
`timescale 1ns/1ps
module lmd_top_chk
   import lmd_pkg::*;
(
   input wire logic                        CLOCK,
   input wire logic                        RST_N,
   input wire logic                        CE,
   input wire logic                        CMD_VALID,
   input wire lmd_cmd_t                    CMD,
   input wire logic                        CMD_READY,
   input wire logic                        AUTO_BUSY,
   input wire logic                        LEGACY_MOUNT,
   input wire logic [NUM_MOTORS-1:0][15:0] POS_FB,
   input wire logic [NUM_MOTORS-1:0]       STEP,
   input wire logic [NUM_MOTORS-1:0]       DIR,
   input wire logic [NUM_MOTORS-1:0]       MOTOR_BUSY,
   input wire logic [NUM_MOTORS-1:0][15:0] POS,
   input wire logic                        CAL_REQ,
   input wire logic                        LAMP_COND_ON,
   input wire logic                        DM_ENABLED,
   input wire logic                        RSP_VALID,
   input wire lmd_rsp_t                    RSP
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   logic        take;   // Command accepted at this edge
   logic [11:0] gap_d;  // Cycles since last zoom step
   logic [11:0] gap_q;

   assign take = CMD_VALID && CMD_READY && CE;

   // Saturating gap counter, cleared by a step
   always_comb
   begin
      gap_d = (gap_q == 12'hfff) ? gap_q : gap_q + 12'h001;
      if (STEP[0])
      begin
         gap_d = 12'h000;
      end
   end

   // Starts saturated so the first step is never judged
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         gap_q <= 12'hfff;
      end
      else
      begin
         gap_q <= gap_d;
      end
   end

   a_lamp_follows : assert property (
      take && CMD.op == OP_LAMP && CMD.a0 <= ARG_ON |=> LAMP_COND_ON == $past(CMD.a0[0]))
      else $error("lamp setting not followed");
   a_enable_follows : assert property (
      take && CMD.op == OP_ENABLE && CMD.a0 <= ARG_ON |=> DM_ENABLED == $past(CMD.a0[0]))
      else $error("enable setting not followed");
   a_disabled_idle : assert property (
      take && CMD.op == OP_MOVE && !DM_ENABLED && MOTOR_BUSY == 2'h0 |=> MOTOR_BUSY == 2'h0)
      else $error("move acted on while disabled");
   a_auto_no_step : assert property (
      AUTO_BUSY [*2] |-> STEP == 2'h0)
      else $error("step while automatic motion busy");
   a_step_spacing : assert property (
      STEP[0] |-> gap_q >= 12'(STEP_CYC - 1))
      else $error("steps faster than top speed");
   a_step_moves_pos : assert property (
      STEP[0] |-> POS[0] == (DIR[0] ? $past(POS[0]) + 16'h0001 : $past(POS[0]) - 16'h0001))
      else $error("position not following step");
   a_idle_no_step : assert property (
      MOTOR_BUSY[1] == 1'b0 [*2] |-> !STEP[1])
      else $error("step while motor idle");
   a_legacy_cal : assert property (
      take && CMD.op == OP_CENTRE && LEGACY_MOUNT |=> CAL_REQ ##1 !CAL_REQ)
      else $error("calibration request missing");
   a_centre_loads : assert property (
      take && CMD.op == OP_CENTRE && !LEGACY_MOUNT |=> POS == $past(POS_FB))
      else $error("centre did not reload positions");
   a_qparam_words : assert property (
      take && CMD.op == OP_QPARAM |=> ##1 (RSP_VALID && !RSP.last && !CMD_READY) [*4]
      ##1 (RSP_VALID && RSP.last))
      else $error("parameter answer malformed");
   a_qpos_word : assert property (
      take && CMD.op == OP_QPOS && CMD.a0 <= MOTOR_FOCUS |=> RSP_VALID && RSP.last)
      else $error("position answer missing");
   a_move_busy : assert property (
      take && CMD.op == OP_MOVE && CMD.nargs == 2'h2 && CMD.a0 == MOTOR_ZOOM && DM_ENABLED && !AUTO_BUSY
      |=> MOTOR_BUSY[0])
      else $error("positional move not started");
endmodule : lmd_top_chk

bind lmd_top lmd_top_chk u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .CE(CE), .CMD_VALID(CMD_VALID), .CMD(CMD),
   .CMD_READY(CMD_READY), .AUTO_BUSY(AUTO_BUSY), .LEGACY_MOUNT(LEGACY_MOUNT), .POS_FB(POS_FB), .STEP(STEP),
   .DIR(DIR), .MOTOR_BUSY(MOTOR_BUSY), .POS(POS), .CAL_REQ(CAL_REQ), .LAMP_COND_ON(LAMP_COND_ON),
   .DM_ENABLED(DM_ENABLED), .RSP_VALID(RSP_VALID), .RSP(RSP));

/* File: dv/test_lmd_top.sv */
// Command-driven bench for the lens direct-motion controller.
// Assumes lmd_host_model drives commands; short travel keeps moves brief.
`timescale 1ns/1ps
module test_lmd_top;
   import lmd_pkg::*;
   localparam logic [15:0] PMAX  = 16'h0008; // Eight counts of travel
   localparam int          LIMIT = 60000;    // Cycle ceiling for the run
   logic                        clock, rst_n, auto_busy, legacy, cmd_valid, cmd_ready;
   logic                        cal_req, lamp_on, dm_en, rsp_valid;
   lmd_cmd_t                    cmd;
   lmd_rsp_t                    rsp;
   logic [NUM_MOTORS-1:0][15:0] pos_fb, pos;
   logic [NUM_MOTORS-1:0]       step, dir, busy;
   logic [15:0]                 lv [3] = '{16'h0001, 16'h0002, 16'h0000};
   int                          n_fail, num_checks, cycles, i, k;

   lmd_host_model host (.clock(clock), .cmd_ready(cmd_ready), .cmd(cmd), .cmd_valid(cmd_valid));
   lmd_top #(.PHYS_MAX(PMAX), .TICK_LEN(20)) dut (.CLOCK(clock), .RST_N(rst_n), .CE(1'b1),
      .CMD_VALID(cmd_valid), .CMD(cmd), .CMD_READY(cmd_ready), .AUTO_BUSY(auto_busy), .LEGACY_MOUNT(legacy),
      .POS_FB(pos_fb), .STEP(step), .DIR(dir), .MOTOR_BUSY(busy), .POS(pos), .CAL_REQ(cal_req),
      .LAMP_COND_ON(lamp_on), .DM_ENABLED(dm_en), .RSP_VALID(rsp_valid), .RSP(rsp));

   always #10 clock = ~clock;

   // Hang guard
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         n_fail++;
         end_of_test();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         n_fail++;
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge clock);
         #1;
      end
   endtask : tick

   // Answer may land on the take edge or a cycle later
   task automatic wait_rsp();
      for (k = 0; k < 4 && rsp_valid !== 1'b1; k++)
         tick(1);
   endtask : wait_rsp

   task automatic qparam(input logic [4:0][15:0] e);
      host.send(OP_QPARAM, 2'h0, 16'h0, 16'h0, 16'h0);
      wait_rsp();
      for (i = 4; i >= 0; i--)
      begin
         chk({15'h0, rsp_valid}, 16'h0001);
         chk(rsp.data, e[i]);
         chk({15'h0, rsp.last}, {15'h0, i == 0});
         tick(1);
      end
   endtask : qparam

   task automatic qpos(input logic [15:0] m, input logic [15:0] e);
      host.send(OP_QPOS, 2'h1, m, 16'h0, 16'h0);
      wait_rsp();
      chk({15'h0, rsp_valid}, {15'h0, e != 16'hffff});
      chk(rsp.data, e);
      chk({15'h0, rsp.last}, 16'h0001);
   endtask : qpos

   // Motor must go busy, then settle within a bound
   task automatic run_to(input int m, input logic [15:0] e, input logic d);
      tick(1);
      chk({15'h0, busy[m]}, 16'h0001);
      for (k = 0; k < 12000 && busy[m] !== 1'b0; k++)
         tick(1);
      chk(pos[m], e);
      chk({15'h0, dir[m]}, {15'h0, d});
   endtask : run_to

   task automatic end_of_test();
      if (n_fail == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   initial
   begin
      clock     = 1'b0;
      rst_n     = 1'b0;
      auto_busy = 1'b0;
      legacy    = 1'b1;
      pos_fb    = {16'h0003, 16'h0005};
      tick(10);
      rst_n = 1'b1;
      chk({15'h0, dm_en}, 16'h0001);
      chk({14'h0, busy}, 16'h0000);
      qparam({16'h0001, 16'h0000, 16'hffff, 16'h0004, 16'h0002});
      // Older mount: centre asks for calibration only
      host.send(OP_CENTRE, 2'h0, 16'h0, 16'h0, 16'h0);
      chk({15'h0, cal_req}, 16'h0001);
      tick(2);
      chk({14'h0, pos[0][1:0]}, 16'h0000);
      legacy = 1'b0;
      host.send(OP_CENTRE, 2'h0, 16'h0, 16'h0, 16'h0);
      chk({15'h0, cal_req}, 16'h0000);
      tick(1);
      chk(pos[1], 16'h0003);
      run_to(0, PMAX >> 1, 1'b0);
      chk(pos[1], PMAX >> 1);
      for (i = 0; i < 3; i++)
      begin
         host.send(OP_LAMP, 2'h1, lv[i], 16'h0, 16'h0);
         tick(1);
         chk({15'h0, lamp_on}, {15'h0, i != 2});
      end
      host.send(OP_RANGE, 2'h2, 16'h0008, 16'h0008, 16'h0);
      host.send(OP_RANGE, 2'h2, 16'h0000, 16'h0008, 16'h0);
      host.send(OP_DEPTH, 2'h1, 16'h0003, 16'h0, 16'h0);
      host.send(OP_GAIN, 2'h1, 16'h0005, 16'h0, 16'h0);
      qparam({16'h0001, 16'h0000, 16'h0008, 16'h0003, 16'h0005});
      host.send(OP_ENABLE, 2'h1, ARG_OFF, 16'h0, 16'h0);
      chk({15'h0, dm_en}, 16'h0000);
      // Refused moves: disabled, bad motor, bad mode, automatic motion
      for (i = 0; i < 4; i++)
      begin
         auto_busy = (i == 3);
         host.send(OP_MOVE, (i == 2) ? 2'h3 : 2'h2, (i == 1) ? 16'h0002 : MOTOR_ZOOM, 16'h0006, 16'h0002);
         tick(3);
         chk({14'h0, busy}, 16'h0000);
         if (i == 0)
            host.send(OP_ENABLE, 2'h1, ARG_ON, 16'h0, 16'h0);
      end
      auto_busy = 1'b0;
      // Zoom to 6, mode omitted; automatic motion pauses it
      host.send(OP_MOVE, 2'h2, MOTOR_ZOOM, 16'h0006, 16'h0);
      tick(100);
      auto_busy = 1'b1;
      tick(3000);
      chk(pos[0], 16'h0004);
      auto_busy = 1'b0;
      run_to(0, 16'h0006, 1'b1);
      // Focus heads for 7, replaced at 5 by a move to 2
      host.send(OP_MOVE, 2'h3, MOTOR_FOCUS, 16'h0007, ARG_OFF);
      for (k = 0; k < 3000 && pos[1] !== 16'h0005; k++)
         tick(1);
      host.send(OP_MOVE, 2'h3, MOTOR_FOCUS, 16'h0002, ARG_OFF);
      run_to(1, 16'h0002, 1'b0);
      host.send(OP_MOVE, 2'h2, MOTOR_ZOOM, 16'h00c8, 16'h0);
      run_to(0, 16'h0008, 1'b1);
      host.send(OP_RANGE, 2'h2, 16'h0000, 16'h0010, 16'h0);
      qpos(MOTOR_ZOOM, 16'h0010);
      qpos(MOTOR_FOCUS, 16'h0004);
      host.send(OP_QPOS, 2'h1, 16'h0002, 16'h0, 16'h0);
      tick(4);
      chk({15'h0, rsp_valid}, 16'h0000);
      // Tracking inputs seed, then drive speed from change
      for (i = 1; i < 14; i += 4)
         host.send(OP_MOVE, 2'h3, MOTOR_FOCUS, 16'(i), ARG_ON);
      tick(2);
      chk({15'h0, busy[1]}, 16'h0001);
      // Inputs have stopped changing, so the motor must settle soon
      for (k = 0; k < 200 && busy[1] !== 1'b0; k++)
         tick(1);
      chk({15'h0, busy[1]}, 16'h0000);
      end_of_test();
   end
endmodule : test_lmd_top
